/* logic/ramp_upper_pkg.sv */
// Behaviour
// - Signed 32-bit target, read back, resets zero
// - Target write in positioning mode starts move
// - Position arithmetic wraps modulo two to 32
// - Displacement per move within plus/minus 2^31-1
// - 20-bit offset below maximum; above uses halves
// - Zero offset: only full maximum rates used
// - 18-bit upper acceleration, reset zero, used mid-band
// - 18-bit upper deceleration, reset ten, mid-band
`default_nettype none
package ramp_upper_pkg;
  localparam int POS_W = 32;
  localparam int VOFF_W = 20;
  localparam int RATE_W = 18;
  localparam int VEL_W = 23;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] ADDR_TARGET_POSITION = 7'h2d;
  localparam logic [ADDR_W-1:0] ADDR_UPPER_SEGMENT_VELOCITY = 7'h2e;
  localparam logic [ADDR_W-1:0] ADDR_UPPER_SEGMENT_ACCEL = 7'h2f;
  localparam logic [ADDR_W-1:0] ADDR_UPPER_SEGMENT_DECEL = 7'h30;

  localparam logic [POS_W-1:0] TARGET_RESET = 32'h0000_0000;
  localparam logic [VOFF_W-1:0] VOFF_RESET = 20'h0_0000;
  localparam logic [RATE_W-1:0] ACCEL_RESET = 18'h0_0000;
  localparam logic [RATE_W-1:0] DECEL_RESET = 18'h0_000a;
  localparam logic [1:0] RAMP_SELECT_POSITIONING = 2'h0;

  typedef enum logic [3:0] {
    SEG_LOWER = 4'h1,
    SEG_MIDDLE = 4'h2,
    SEG_HALF = 4'h4,
    SEG_FULL = 4'h8
  } segment_t;

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [VEL_W-1:0] present_velocity;
    logic [VEL_W-1:0] maximum_velocity;
    logic [VEL_W-1:0] first_threshold_velocity;
    logic [RATE_W-1:0] maximum_acceleration;
    logic [RATE_W-1:0] maximum_deceleration;
    logic accelerating;
    logic [POS_W-1:0] actual_position;
  } motion_t;

  typedef struct packed {
    logic [POS_W-1:0] target_position;
    logic [VOFF_W-1:0] upper_segment_velocity;
    logic [RATE_W-1:0] upper_segment_accel;
    logic [RATE_W-1:0] upper_segment_decel;
    logic start;
    segment_t segment;
    logic [RATE_W-1:0] rate;
    logic [VEL_W-1:0] second_threshold;
    logic [POS_W-1:0] displacement;
    logic [DATA_W-1:0] rdata;
  } state_t;
endpackage
`default_nettype wire

/* logic/ramp_upper_segments.sv */
`default_nettype none
module ramp_upper_segments
  import ramp_upper_pkg::*;
(
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire reg_req_t REG_REQ,
  output logic [DATA_W-1:0] REG_RDATA,
  input wire logic [1:0] RAMP_SELECT,
  input wire motion_t MOTION,
  output logic [POS_W-1:0] TARGET_POSITION,
  output logic START_POSITIONING,
  output segment_t SEGMENT,
  output logic [RATE_W-1:0] SEGMENT_RATE,
  output logic [VEL_W-1:0] SECOND_THRESHOLD_VELOCITY,
  output logic [POS_W-1:0] MOVE_DISPLACEMENT,
  output logic MOVE_DIR_NEG
);
  state_t state_r;
  state_t state_nxt;
  logic [VEL_W-1:0] voff_wide;
  logic [VEL_W-1:0] second_v;

  always_comb begin
    state_nxt = state_r;
    state_nxt.start = 1'b0;
    voff_wide = VEL_W'(state_r.upper_segment_velocity);
    second_v = '0;

    if (REG_REQ.wr) begin
      unique case (REG_REQ.addr)
        ADDR_TARGET_POSITION: begin
          state_nxt.target_position = REG_REQ.wdata;
          // Every rewrite in positioning mode relaunches, so a raised rate mid-move takes effect
          state_nxt.start = (RAMP_SELECT == RAMP_SELECT_POSITIONING);
        end
        ADDR_UPPER_SEGMENT_VELOCITY: begin
          state_nxt.upper_segment_velocity = REG_REQ.wdata[VOFF_W-1:0];
        end
        ADDR_UPPER_SEGMENT_ACCEL: begin
          state_nxt.upper_segment_accel = REG_REQ.wdata[RATE_W-1:0];
        end
        ADDR_UPPER_SEGMENT_DECEL: begin
          // A zero here would stall a positioning stop; the host must avoid it
          state_nxt.upper_segment_decel = REG_REQ.wdata[RATE_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Saturate so an offset above the maximum never wraps to a huge threshold
    if (MOTION.maximum_velocity > voff_wide) begin
      second_v = MOTION.maximum_velocity - voff_wide;
    end
    state_nxt.second_threshold = second_v;

    if (MOTION.present_velocity < MOTION.first_threshold_velocity) begin
      state_nxt.segment = SEG_LOWER;
    end else if (state_r.upper_segment_velocity == VOFF_RESET) begin
      state_nxt.segment = SEG_FULL;
    end else if (MOTION.present_velocity < second_v) begin
      state_nxt.segment = SEG_MIDDLE;
    end else begin
      state_nxt.segment = SEG_HALF;
    end

    unique case (state_nxt.segment)
      SEG_LOWER: begin
        // Lower band rates live outside this block
        state_nxt.rate = '0;
      end
      SEG_MIDDLE: begin
        state_nxt.rate = MOTION.accelerating ? state_r.upper_segment_accel : state_r.upper_segment_decel;
      end
      SEG_HALF: begin
        state_nxt.rate = MOTION.accelerating ? (MOTION.maximum_acceleration >> 1)
                                             : (MOTION.maximum_deceleration >> 1);
      end
      SEG_FULL: begin
        state_nxt.rate = MOTION.accelerating ? MOTION.maximum_acceleration : MOTION.maximum_deceleration;
      end
    endcase

    // Plain 32-bit subtraction wraps; sign is valid within the displacement limit
    state_nxt.displacement = state_r.target_position - MOTION.actual_position;

    unique case (REG_REQ.addr)
      ADDR_TARGET_POSITION: state_nxt.rdata = state_r.target_position;
      ADDR_UPPER_SEGMENT_VELOCITY: state_nxt.rdata = DATA_W'(state_r.upper_segment_velocity);
      ADDR_UPPER_SEGMENT_ACCEL: state_nxt.rdata = DATA_W'(state_r.upper_segment_accel);
      ADDR_UPPER_SEGMENT_DECEL: state_nxt.rdata = DATA_W'(state_r.upper_segment_decel);
      default: state_nxt.rdata = '0;
    endcase
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_r.target_position <= TARGET_RESET;
      state_r.upper_segment_velocity <= VOFF_RESET;
      state_r.upper_segment_accel <= ACCEL_RESET;
      state_r.upper_segment_decel <= DECEL_RESET;
      state_r.start <= 1'b0;
      state_r.segment <= SEG_LOWER;
      state_r.rate <= '0;
      state_r.second_threshold <= '0;
      state_r.displacement <= '0;
      state_r.rdata <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign REG_RDATA = state_r.rdata;
  assign TARGET_POSITION = state_r.target_position;
  assign START_POSITIONING = state_r.start;
  assign SEGMENT = state_r.segment;
  assign SEGMENT_RATE = state_r.rate;
  assign SECOND_THRESHOLD_VELOCITY = state_r.second_threshold;
  assign MOVE_DISPLACEMENT = state_r.displacement;
  assign MOVE_DIR_NEG = state_r.displacement[POS_W-1];
endmodule
`default_nettype wire

/* verification/ramp_upper_checker.sv */
`default_nettype none
module ramp_upper_checker
  import ramp_upper_pkg::*;
(
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire reg_req_t REG_REQ,
  input wire logic [1:0] RAMP_SELECT,
  input wire motion_t MOTION,
  input wire logic [POS_W-1:0] TARGET_POSITION,
  input wire logic START_POSITIONING,
  input wire segment_t SEGMENT,
  input wire logic [RATE_W-1:0] SEGMENT_RATE,
  input wire logic [POS_W-1:0] MOVE_DISPLACEMENT,
  input wire logic MOVE_DIR_NEG
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  wire logic wt = REG_REQ.wr && REG_REQ.addr == ADDR_TARGET_POSITION;
  a_target_kept: assert property (wt |=> TARGET_POSITION == $past(REG_REQ.wdata)) else $error("target lost");
  a_start_pulse: assert property (wt && RAMP_SELECT == RAMP_SELECT_POSITIONING |=> START_POSITIONING) else $error("no start");
  a_start_quiet: assert property (!(wt && RAMP_SELECT == RAMP_SELECT_POSITIONING) |=> !START_POSITIONING) else $error("stray start");
  a_disp_wraps: assert property ($past(ARST_N) |-> MOVE_DISPLACEMENT ==
    $past(TARGET_POSITION) - $past(MOTION.actual_position)) else $error("bad displacement");
  a_dir_sign: assert property (MOVE_DIR_NEG == MOVE_DISPLACEMENT[POS_W-1]) else $error("bad direction");
  a_half_accel: assert property (SEGMENT == SEG_HALF && $past(MOTION.accelerating) |->
    SEGMENT_RATE == $past(MOTION.maximum_acceleration) >> 1) else $error("bad half rate");
  a_full_decel: assert property (SEGMENT == SEG_FULL && !$past(MOTION.accelerating) |->
    SEGMENT_RATE == $past(MOTION.maximum_deceleration)) else $error("bad full rate");
  a_lower_idle: assert property (MOTION.present_velocity < MOTION.first_threshold_velocity |=>
    SEGMENT == SEG_LOWER && SEGMENT_RATE == 0) else $error("bad lower segment");
  c_start: cover property (START_POSITIONING);
  c_half: cover property (SEGMENT == SEG_HALF);
  c_middle: cover property (SEGMENT == SEG_MIDDLE);
endmodule
bind ramp_upper_segments ramp_upper_checker chk (.*);
`default_nettype wire

/* verification/host_model.sv */
`default_nettype none
module host_model
  import ramp_upper_pkg::*;
(
  input wire logic clock,
  input wire logic [DATA_W-1:0] rdata,
  output var reg_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // Released data is inverted so a stale word can never look valid
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock) req <= '{1'b1, a, d};
    @(posedge clock) req <= '{1'b0, a, ~d};
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clock) req <= '{1'b0, a, 32'h0000_0000};
    @(posedge clock) #1 d = rdata;
  endtask
endmodule
`default_nettype wire

/* verification/ramp_upper_segments_tb.sv */
`default_nettype none
module ramp_upper_segments_tb
  import ramp_upper_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, arst_n, start, neg;
  logic [1:0] sel;
  reg_req_t req;
  motion_t mot;
  segment_t seg;
  logic [RATE_W-1:0] rate;
  logic [VEL_W-1:0] second_seen;
  logic [DATA_W-1:0] rdata, tgt, disp, d;
  int err_count, n_checks, cyc;
  host_model h (.clock(clock), .rdata(rdata), .req(req));
  ramp_upper_segments dut (.CLOCK(clock), .ARST_N(arst_n), .REG_REQ(req), .REG_RDATA(rdata), .RAMP_SELECT(sel),
    .MOTION(mot), .TARGET_POSITION(tgt), .START_POSITIONING(start), .SEGMENT(seg), .SEGMENT_RATE(rate),
    .SECOND_THRESHOLD_VELOCITY(second_seen), .MOVE_DISPLACEMENT(disp), .MOVE_DIR_NEG(neg));
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) err_count++;
    if (s !== e) $display("MISMATCH %0t got %h want %h", $time, s, e);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_regs;
    for (int i = 0; i < 5; i++) begin
      h.rd(ADDR_TARGET_POSITION + 7'(i), d);
      check(d, i == 3 ? 32'h0000_000a : 32'h0000_0000);
      h.wr(ADDR_TARGET_POSITION + 7'(i), 32'hffff_ffff);
      h.rd(ADDR_TARGET_POSITION + 7'(i), d);
      check(d, i == 0 ? 32'hffff_ffff : i == 1 ? 32'h000f_ffff : i < 4 ? 32'h0003_ffff : 32'h0000_0000);
    end
    $display("registers done");
  endtask
  // A rewrite of the same target must pulse again; another ramp mode must not
  task automatic t_start;
    for (int i = 0; i < 3; i++) begin
      sel <= i == 1 ? 2'h1 : RAMP_SELECT_POSITIONING;
      h.wr(ADDR_TARGET_POSITION, 32'h8000_0000);
      #1 check(start, i != 1);
    end
    @(posedge clock) #1 check(disp, 32'hffff_ffff);
    check(neg, 1'b1);
    check(tgt, 32'h8000_0000);
    $display("start done");
  endtask
  task automatic seg_case(input logic [VEL_W-1:0] v, input logic a, input segment_t s, input logic [RATE_W-1:0] r);
    mot.present_velocity <= v;
    mot.accelerating <= a;
    @(posedge clock) #1 check(seg, s);
    check(rate, r);
  endtask
  task automatic t_seg;
    h.wr(ADDR_UPPER_SEGMENT_VELOCITY, 32'h0000_1000);
    h.wr(ADDR_UPPER_SEGMENT_ACCEL, 32'h0000_0123);
    h.wr(ADDR_UPPER_SEGMENT_DECEL, 32'h0000_0456);
    seg_case(23'h00_0080, 1'b1, SEG_LOWER, 18'h0_0000);
    seg_case(23'h00_0200, 1'b1, SEG_MIDDLE, 18'h0_0123);
    seg_case(23'h00_0200, 1'b0, SEG_MIDDLE, 18'h0_0456);
    seg_case(23'h0f_f000, 1'b1, SEG_HALF, 18'h0_0080);
    check(second_seen, 23'h0f_f000);
    h.wr(ADDR_UPPER_SEGMENT_VELOCITY, 32'h0000_0000);
    seg_case(23'h0f_f000, 1'b0, SEG_FULL, 18'h0_0203);
    $display("segments done");
  endtask
  initial forever #5 clock = ~clock;
  always @(posedge clock)
    if (++cyc > 999) begin
      err_count++;
      print_verdict;
    end
  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    sel = 2'h1;
    mot = '{23'h00_0000, 23'h10_0000, 23'h00_0100, 18'h0_0101, 18'h0_0203, 1'b1, 32'h8000_0001};
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    t_regs;
    t_start;
    t_seg;
    print_verdict;
  end
endmodule
`default_nettype wire
